// ===== pct_cam_track.sv
// Position cam track generator with APB register slave
// Function
// - Up to 32 cams drive one output
// - Cam positions relative to track, non-negative
// - Only cams starting inside track count
// - Time cam stays on past track end
// - Distance cam clipped off at track end
// - Cams outside track ignored until length grows
// - Origin at reference, track repeats both ways
// - Reference folded into modulo range
// - Report current track origin, left boundary
// - Report position relative to track origin
// - One cam type per track
// - Selectable source: setpoint, actual, encoder
// - Homing jump continues from new position
// - Homing skips untriggered time cams only
// - Two edges timestamped, one edge plain
// - Last on and off edge win
// - Cam needs valid flag and mask bit
// - Ascending order positive, descending negative
// - Distance cam on inside its range
// - Time cam on at start for duration
// - Combine cams by OR or AND
// - Separate lead for on and off edges
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module pct_cam_track #(
   parameter int CAMS = 32, // Number of cams
   parameter int DUR_W = 16, // Width of time cam duration, in control cycles
   parameter int CTRL_CYCLE_NS = pct_pkg::CTRL_CYCLE_NS_DEF // Control cycle
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pct_pkg::pct_src_t src_pos,
   input wire logic homing_command,
   output logic track_out,
   output pct_pkg::pct_edge_t edge_out,
   output logic signed [31:0] track_origin_position,
   output logic signed [31:0] position_within_track
);
   import pct_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   localparam int CYCLE_DIV = CTRL_CYCLE_NS / CLK_PERIOD_NS; // Clocks per control cycle
   typedef enum logic [1:0] {ST_IDLE, ST_REF, ST_ORG, ST_EVAL} pct_state_t;
   pct_state_t fsm_r; // Evaluation sequencer
   pct_ctrl_t ctrl_r; // Control word
   logic [31:0] mask_r; // cam_enable_mask
   logic [31:0] valid_r; // Cam valid flags
   logic signed [31:0] ref_r; // track_reference_position
   logic [30:0] len_r; // track_length
   logic [30:0] mod_r; // Modulo length
   logic [7:0] lead_on_r; // switch_on_lead_time, control cycles
   logic [7:0] lead_off_r; // switch_off_lead_time, control cycles
   logic [4:0] sel_r; // Cam index for indirect access
   logic [30:0] cam_start_r [CAMS]; // Start positions on the track
   logic [30:0] cam_end_r [CAMS]; // End position, or duration in low bits
   logic [DUR_W-1:0] tmr_r [CAMS]; // Time cam on-counters
   logic [DUR_W-1:0] tmr_nxt [CAMS];
   logic [CAMS-1:0] cam_st_r; // Cam states
   logic [CAMS-1:0] st_nxt;
   logic [CAMS-1:0] eff; // Cams taking part
   logic [31:0] div_r; // Control-cycle divider
   logic tick_r; // One pulse per control cycle
   logic signed [31:0] pos_lat_r; // Position sample of this cycle
   logic signed [31:0] prev_pos_r; // Sample of the previous cycle
   logic signed [31:0] ref_f_r; // Folded reference
   logic signed [31:0] origin_r; // Current track origin
   logic active_r; // Origin has been placed
   logic fresh_r; // First evaluation after placing the origin
   logic hom_pend_r; // Homing jump not yet evaluated
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic track_out_r;
   pct_edge_t edge_r;
   logic signed [31:0] trkpos_r;
   logic signed [31:0] rel_w, len_s, mod_s, half_mod, dlt_raw, dlt, prev_rel;
   logic signed [31:0] adv_on, adv_off, xon, xoff;
   logic signed [40:0] prod_on, prod_off;
   logic skip, dir_pos, dir_neg, any_on, any_off, comb_out, hit;
   logic [31:0] on_pos, off_pos, rd_mux;
   logic wr_acc;

   // ************************************************************
   // APB slave
   // ************************************************************
   // Read mux and address decode; unmapped addresses answer with pslverr
   always_comb begin
      hit = 1'b1;
      rd_mux = 32'h00000000;
      unique case (paddr)
         OFS_CTRL: rd_mux = {25'h0, ctrl_r};
         OFS_MASK: rd_mux = mask_r;
         OFS_VALID: rd_mux = valid_r;
         OFS_REF: rd_mux = ref_r;
         OFS_LEN: rd_mux = {1'b0, len_r};
         OFS_MOD: rd_mux = {1'b0, mod_r};
         OFS_LEAD: rd_mux = {16'h0, lead_off_r, lead_on_r};
         OFS_SEL: rd_mux = {27'h0, sel_r};
         OFS_START: rd_mux = {1'b0, cam_start_r[sel_r]};
         OFS_END: rd_mux = {1'b0, cam_end_r[sel_r]};
         OFS_STAT: rd_mux = {30'h0, active_r, track_out_r};
         OFS_ORIGIN: rd_mux = origin_r;
         OFS_TRKPOS: rd_mux = trkpos_r;
         OFS_CAMST: rd_mux = 32'(cam_st_r);
         default: hit = 1'b0;
      endcase
   end

   // Answer one cycle after setup; read data latched so it comes from a flop
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else if (psel && !penable) begin
         pready_r <= 1'b1;
         pslverr_r <= !hit;
         prdata_r <= pwrite ? 32'h00000000 : rd_mux;
      end else begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   // Write takes effect only at the completing access edge
   assign wr_acc = psel && penable && pwrite && pready_r && hit;

   // Configuration registers; read-only offsets ignore writes
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r <= CTRL_RST;
         mask_r <= MASK_RST;
         valid_r <= VALID_RST;
         ref_r <= 32'h00000000;
         len_r <= LEN_RST;
         mod_r <= 31'h00000000;
         lead_on_r <= 8'h00;
         lead_off_r <= 8'h00;
         sel_r <= 5'h00;
         for (int i = 0; i < CAMS; i++) begin
            cam_start_r[i] <= 31'h00000000;
            cam_end_r[i] <= 31'h00000000;
         end
      end else if (wr_acc) begin
         unique case (paddr)
            OFS_CTRL: ctrl_r <= pct_ctrl_t'(pwdata[CTRL_W-1:0]);
            OFS_MASK: mask_r <= pwdata;
            OFS_VALID: valid_r <= pwdata;
            OFS_REF: ref_r <= pwdata;
            OFS_LEN: len_r <= pwdata[30:0];
            OFS_MOD: mod_r <= pwdata[30:0];
            OFS_LEAD: begin
               lead_on_r <= pwdata[LEAD_ON_LSB +: 8];
               lead_off_r <= pwdata[LEAD_OFF_LSB +: 8];
            end
            OFS_SEL: sel_r <= pwdata[4:0];
            // Bit 31 dropped: track positions cannot be negative
            OFS_START: cam_start_r[sel_r] <= pwdata[30:0];
            OFS_END: cam_end_r[sel_r] <= pwdata[30:0];
            default: ;
         endcase
      end
   end

   // ************************************************************
   // Control cycle and sequencing
   // ************************************************************
   // Divider gives one tick per position-control cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_r <= 32'h00000000;
         tick_r <= 1'b0;
      end else begin
         tick_r <= (div_r == 32'(CYCLE_DIV - 1));
         div_r <= (div_r == 32'(CYCLE_DIV - 1)) ? 32'h00000000 : div_r + 32'h00000001;
      end
   end

   assign rel_w = pos_lat_r - origin_r;
   assign len_s = $signed({1'b0, len_r});
   assign mod_s = $signed({1'b0, mod_r});

   // Sequencer; a tick that lands while folding is dropped, the cycle is skipped
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fsm_r <= ST_IDLE;
      end else begin
         unique case (fsm_r)
            ST_IDLE: if (tick_r) fsm_r <= ST_REF;
            ST_REF: begin
               if (!ctrl_r.mod_en || mod_r == 31'h0 || (ref_f_r >= 0 && ref_f_r < mod_s)) begin
                  fsm_r <= ST_ORG;
               end
            end
            ST_ORG: begin
               if (!ctrl_r.en || (active_r && (len_r == 31'h0 || (rel_w >= 0 && rel_w < len_s)))) begin
                  fsm_r <= ST_EVAL;
               end
            end
            ST_EVAL: fsm_r <= ST_IDLE;
         endcase
      end
   end

   // Sample the selected source and fold the reference one step per clock
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pos_lat_r <= 32'h00000000;
         ref_f_r <= 32'h00000000;
      end else if (fsm_r == ST_IDLE && tick_r) begin
         unique case (ctrl_r.src)
            SRC_SETP: pos_lat_r <= src_pos.setpoint;
            SRC_ACT: pos_lat_r <= src_pos.actual;
            default: pos_lat_r <= src_pos.encoder;
         endcase
         ref_f_r <= ref_r;
      end else if (fsm_r == ST_REF && ctrl_r.mod_en && mod_r != 31'h0) begin
         if (ref_f_r < 0) begin
            ref_f_r <= ref_f_r + mod_s;
         end else if (ref_f_r >= mod_s) begin
            ref_f_r <= ref_f_r - mod_s;
         end
      end
   end

   // Track origin: placed at the reference, then stepped by whole tracks
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         origin_r <= 32'h00000000;
         active_r <= 1'b0;
         fresh_r <= 1'b0;
      end else if (fsm_r == ST_ORG) begin
         if (!ctrl_r.en) begin
            active_r <= 1'b0;
         end else if (!active_r) begin
            origin_r <= ref_f_r;
            active_r <= 1'b1;
            fresh_r <= 1'b1;
         end else if (len_r != 31'h0 && rel_w < 0) begin
            origin_r <= origin_r - len_s;
         end else if (len_r != 31'h0 && rel_w >= len_s) begin
            origin_r <= origin_r + len_s;
         end
      end else if (fsm_r == ST_EVAL) begin
         fresh_r <= 1'b0;
      end
   end

   // Homing jump pending; a new request in the evaluating cycle wins
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hom_pend_r <= 1'b0;
      end else if (homing_command) begin
         hom_pend_r <= 1'b1;
      end else if (fsm_r == ST_EVAL) begin
         hom_pend_r <= 1'b0;
      end
   end

   // ************************************************************
   // Cam evaluation
   // ************************************************************
   // Motion since last sample; a jump or fresh start counts as no motion
   assign skip = hom_pend_r || fresh_r;
   assign dlt_raw = pos_lat_r - prev_pos_r;
   assign half_mod = $signed({2'b00, mod_r[30:1]});
   always_comb begin
      if (skip) begin
         dlt = 32'h00000000;
      end else if (ctrl_r.mod_en && mod_r != 31'h0 && dlt_raw > half_mod) begin
         dlt = dlt_raw - mod_s;
      end else if (ctrl_r.mod_en && mod_r != 31'h0 && dlt_raw < -half_mod) begin
         dlt = dlt_raw + mod_s;
      end else begin
         dlt = dlt_raw;
      end
   end
   assign dir_pos = dlt > 0;
   assign dir_neg = dlt < 0;
   assign prev_rel = rel_w - dlt;
   // Lead time becomes a position advance at the present speed
   assign prod_on = dlt * $signed({1'b0, lead_on_r});
   assign prod_off = dlt * $signed({1'b0, lead_off_r});
   assign adv_on = $signed(prod_on[31:0]);
   assign adv_off = $signed(prod_off[31:0]);
   assign xon = rel_w + adv_on;
   assign xoff = rel_w + adv_off;

   // Participation: valid, unmasked and starting inside the track
   always_comb begin
      for (int i = 0; i < CAMS; i++) begin
         eff[i] = valid_r[i] && mask_r[i] && (cam_start_r[i] < len_r);
      end
   end

   // Walk the cams in motion order so the last edge of each kind wins
   always_comb begin
      int idx;
      logic signed [31:0] s, e;
      logic [DUR_W-1:0] dur, load;
      logic on, trig;
      idx = 0;
      s = 32'h00000000;
      e = 32'h00000000;
      dur = '0;
      load = '0;
      on = 1'b0;
      trig = 1'b0;
      any_on = 1'b0;
      any_off = 1'b0;
      on_pos = 32'h00000000;
      off_pos = 32'h00000000;
      st_nxt = '0;
      tmr_nxt = tmr_r; // Every timer is rewritten by the walk below
      for (int k = 0; k < CAMS; k++) begin
         idx = dir_neg ? CAMS - 1 - k : k;
         s = $signed({1'b0, cam_start_r[idx]});
         // Ranges reaching past the track end stop at the end
         e = (cam_end_r[idx] > len_r) ? len_s : $signed({1'b0, cam_end_r[idx]});
         dur = cam_end_r[idx][DUR_W-1:0];
         load = (dur > DUR_W'(lead_off_r)) ? dur - DUR_W'(lead_off_r) : DUR_W'(1);
         tmr_nxt[idx] = (tmr_r[idx] != '0) ? tmr_r[idx] - DUR_W'(1) : '0;
         if (ctrl_r.time_type) begin
            trig = eff[idx] && !skip && ((dir_pos && prev_rel < s && xon >= s) ||
                   (dir_neg && prev_rel >= s && xon < s));
            if (trig) begin
               tmr_nxt[idx] = load;
            end
            on = tmr_nxt[idx] != '0;
         end else if (cam_st_r[idx]) begin
            on = eff[idx] && xoff >= s && xoff < e;
         end else begin
            on = eff[idx] && xon >= s && xon < e;
         end
         if (!ctrl_r.en) begin
            on = 1'b0;
            tmr_nxt[idx] = '0;
         end
         st_nxt[idx] = on;
         if (on && !cam_st_r[idx]) begin
            any_on = 1'b1;
            on_pos = (!ctrl_r.time_type && dir_neg) ? e : s;
         end
         if (!on && cam_st_r[idx]) begin
            any_off = 1'b1;
            off_pos = ctrl_r.time_type ? rel_w : (dir_neg ? s : e);
         end
      end
   end

   // One output from all cams
   assign comb_out = ctrl_r.and_sel ? (&(st_nxt | ~eff) && |eff) : |st_nxt;

   // Cam states and timers, updated once per control cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cam_st_r <= '0;
         prev_pos_r <= 32'h00000000;
         for (int i = 0; i < CAMS; i++) begin
            tmr_r[i] <= '0;
         end
      end else if (fsm_r == ST_EVAL) begin
         cam_st_r <= st_nxt;
         prev_pos_r <= pos_lat_r;
         for (int i = 0; i < CAMS; i++) begin
            tmr_r[i] <= tmr_nxt[i];
         end
      end
   end

   // Output level, edges and position reports
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         track_out_r <= 1'b0;
         edge_r <= '0;
         trkpos_r <= 32'h00000000;
      end else if (fsm_r == ST_EVAL) begin
         track_out_r <= comb_out;
         edge_r.on_pos <= on_pos;
         edge_r.off_pos <= off_pos;
         trkpos_r <= rel_w;
         if (ctrl_r.plain_out) begin
            // Plain output shows only the level change, at most one edge
            edge_r.on <= comb_out && !track_out_r;
            edge_r.off <= !comb_out && track_out_r;
         end else begin
            edge_r.on <= any_on;
            edge_r.off <= any_off;
         end
      end else begin
         edge_r.on <= 1'b0;
         edge_r.off <= 1'b0;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign track_out = track_out_r;
   assign edge_out = edge_r;
   assign track_origin_position = origin_r;
   assign position_within_track = trkpos_r;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_dist_eff_only: assert property (fsm_r == ST_EVAL && !ctrl_r.time_type |=>
      (cam_st_r & ~$past(eff)) == '0) else $error("ineffective distance cam on");
   a_or_combine: assert property (fsm_r == ST_EVAL && !ctrl_r.and_sel |=>
      track_out_r == (|cam_st_r)) else $error("OR combine wrong");
   a_trkpos_range: assert property (fsm_r == ST_EVAL && ctrl_r.en && len_r != 31'h0 |=>
      trkpos_r >= 0 && trkpos_r < len_s) else $error("track position outside track");
   a_origin_rel: assert property (fsm_r == ST_EVAL |=>
      trkpos_r == pos_lat_r - origin_r) else $error("track position not from origin");
   a_plain_one_edge: assert property (ctrl_r.plain_out |->
      !(edge_r.on && edge_r.off)) else $error("two edges in plain mode");
   a_plain_edge_lvl: assert property (ctrl_r.plain_out && edge_r.on |->
      track_out_r && !$past(track_out_r)) else $error("on edge without rise");
   a_disabled_off: assert property (fsm_r == ST_EVAL && !ctrl_r.en |=>
      !track_out_r && cam_st_r == '0) else $error("disabled track drives output");
   a_ref_folded: assert property (fsm_r == ST_REF ##1 fsm_r == ST_ORG &&
      ctrl_r.mod_en && mod_r != 31'h0 |-> ref_f_r >= 0 && ref_f_r < mod_s)
      else $error("reference not folded");
   a_time_hold: assert property (fsm_r == ST_EVAL && ctrl_r.en &&
      ctrl_r.time_type && tmr_r[0] > DUR_W'(1) |=> cam_st_r[0]) else $error("time cam dropped early");
   a_tick_eval: assert property ($rose(tick_r) && fsm_r == ST_IDLE |=> fsm_r == ST_REF)
      else $error("control tick not taken");

   c_time_trig: cover property (fsm_r == ST_EVAL && ctrl_r.time_type && any_on);
   c_homing: cover property (fsm_r == ST_EVAL && hom_pend_r && ctrl_r.en);
   c_neg_edge: cover property (fsm_r == ST_EVAL && dir_neg && any_on);
   c_two_edges: cover property (edge_r.on && edge_r.off);
endmodule // pct_cam_track
`default_nettype wire

// ===== pct_pkg.sv
// Package of constants and carrier types for the position cam track generator
package pct_pkg;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 100; // System clock period, 10 MHz
   localparam int CTRL_CYCLE_NS_DEF = 1000000; // Default position-control cycle

   // ************************************************************
   // Register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00; // Control word
   localparam logic [7:0] OFS_MASK = 8'h04; // Cam enable mask
   localparam logic [7:0] OFS_VALID = 8'h08; // Cam valid flags
   localparam logic [7:0] OFS_REF = 8'h0C; // Track reference position
   localparam logic [7:0] OFS_LEN = 8'h10; // Track length
   localparam logic [7:0] OFS_MOD = 8'h14; // Modulo length of the source
   localparam logic [7:0] OFS_LEAD = 8'h18; // Switch-on and switch-off lead times
   localparam logic [7:0] OFS_SEL = 8'h1C; // Cam index for start and end access
   localparam logic [7:0] OFS_START = 8'h20; // Start position of selected cam
   localparam logic [7:0] OFS_END = 8'h24; // End position or duration of selected cam
   localparam logic [7:0] OFS_STAT = 8'h28; // Status, read only
   localparam logic [7:0] OFS_ORIGIN = 8'h2C; // Track origin position, read only
   localparam logic [7:0] OFS_TRKPOS = 8'h30; // Position within track, read only
   localparam logic [7:0] OFS_CAMST = 8'h34; // Cam states, read only

   // ************************************************************
   // Field layouts and reset values
   // ************************************************************
   localparam int CTRL_W = 7; // Used bits of the control word
   localparam int LEAD_ON_LSB = 0; // Switch-on lead time field
   localparam int LEAD_OFF_LSB = 8; // Switch-off lead time field
   localparam int STAT_OUT_BIT = 0; // Output level
   localparam int STAT_ACT_BIT = 1; // Track active
   localparam logic [31:0] MASK_RST = 32'h0FFFFFFF; // Cams 0 to 27 enabled
   localparam logic [31:0] VALID_RST = 32'h00000000; // No cam valid
   localparam logic [30:0] LEN_RST = 31'h00000000; // Empty track
   localparam logic [1:0] SRC_SETP = 2'h0; // Axis position setpoint
   localparam logic [1:0] SRC_ACT = 2'h1; // Axis actual position
   localparam logic [1:0] SRC_ENC = 2'h2; // External encoder position

   // Control word, bit 6 first
   typedef struct packed {
      logic plain_out; // 1: plain digital output, one edge per cycle
      logic mod_en; // Source wraps at modulo length
      logic [1:0] src; // Position source select
      logic and_sel; // output_combine_select: 0 OR, 1 AND
      logic time_type; // 0 distance cams, 1 time-based cams
      logic en; // track_enable_command
   } pct_ctrl_t;
   localparam pct_ctrl_t CTRL_RST = pct_ctrl_t'(7'h00);

   // Position sources
   typedef struct packed {
      logic signed [31:0] setpoint;
      logic signed [31:0] actual;
      logic signed [31:0] encoder;
   } pct_src_t;

   // Edges emitted in one control cycle
   typedef struct packed {
      logic on;
      logic off;
      logic [31:0] on_pos;
      logic [31:0] off_pos;
   } pct_edge_t;
endpackage

// ===== pct_src_model.sv
// Position source model: axis setpoint, actual position and encoder
`timescale 1ns/100ps
`default_nettype none
module pct_src_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic signed [31:0] tgt,
   output pct_pkg::pct_src_t src_pos,
   output logic arrived
);
   import pct_pkg::*;
   logic signed [31:0] pos_r; // Actual axis position
   // ************************************************************
   // Motion
   // ************************************************************
   // One unit a clock, so no motion looks like a jump to the track
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pos_r <= 32'sh0;
      end else if (pos_r < tgt) begin
         pos_r <= pos_r + 32'sh1;
      end else if (pos_r > tgt) begin
         pos_r <= pos_r - 32'sh1;
      end
   end
   // Three sources differ so a wrong select shows up
   assign src_pos = '{setpoint: pos_r + 32'sh0A, actual: pos_r, encoder: pos_r + 32'sh14};
   assign arrived = (pos_r == tgt);
endmodule // pct_src_model
`default_nettype wire

// ===== tb_top.sv
// Testbench for the position cam track generator
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import pct_pkg::*;
   logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, arrived, track_out, pslverr, pready;
   logic hom = 0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] on_seen = 32'h0;
   pct_edge_t edg;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic signed [31:0] tgt = 32'sh0, org, trk;
   pct_src_t src_pos;
   int fails = 0, cmp_count = 0, cyc = 0;
   always #50 clk = ~clk;
   pct_src_model pct_src_model_inst (.clk(clk), .sys_rst(sys_rst), .tgt(tgt), .src_pos(src_pos),
      .arrived(arrived));
   pct_cam_track #(.CTRL_CYCLE_NS(2000)) pct_cam_track_inst (.clk(clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_pos(src_pos),
      .homing_command(hom), .track_out(track_out), .edge_out(edg), .track_origin_position(org),
      .position_within_track(trk));
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic tally_and_finish();
      if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Setup then access, held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let an edge pass so the next call never reassigns psel in this step
      @(posedge clk);
   endtask
   // Evaluation lands 3 to 4 clocks after a 20-clock tick, later while the reference folds or the origin steps; two ticks are enough
   task automatic settle();
      repeat (45) @(posedge clk);
   endtask
   task automatic go(input logic signed [31:0] p);
      tgt <= p;
      repeat (2) @(posedge clk);
      while (arrived !== 1'b1) @(posedge clk);
      settle();
   endtask
   task automatic expect_pos(input logic o, input int ex_org, input int ex_trk);
      check({31'h0, track_out}, {31'h0, o});
      check(org, ex_org);
      check(trk, ex_trk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         tally_and_finish();
      end
   end
   // Keep the position of the latest switch-on edge pulse
   always @(posedge clk) begin
      if (edg.on === 1'b1) on_seen <= edg.on_pos;
   end
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      apb(0, OFS_MASK, 0);
      check(rd, 32'h0FFFFFFF);
      apb(0, OFS_VALID, 0);
      check(rd, 32'h00000000);
      apb(0, 8'h40, 0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      apb(1, OFS_REF, 32'd1000);
      apb(1, OFS_LEN, 32'd100);
      apb(1, OFS_SEL, 32'd0);
      apb(1, OFS_START, 32'd10);
      apb(1, OFS_END, 32'd20);
      apb(1, OFS_SEL, 32'd1);
      apb(1, OFS_START, 32'd150); // Outside the track for now
      apb(1, OFS_END, 32'd170);
      apb(1, OFS_VALID, 32'h3);
      apb(1, OFS_CTRL, 32'h09); // Enable, distance cams, OR, actual position
      go(1015);
      expect_pos(1, 1000, 15);
      go(1155);
      expect_pos(0, 1100, 55);
      go(985);
      expect_pos(0, 900, 85);
      go(1015);
      apb(1, OFS_MASK, 32'h0FFFFFFE);
      settle();
      check({31'h0, track_out}, 32'h0);
      apb(1, OFS_MASK, 32'h0FFFFFFF);
      apb(1, OFS_LEN, 32'd200);
      go(1155);
      expect_pos(1, 1000, 155);
      apb(1, OFS_CTRL, 32'h0D);
      settle();
      check({31'h0, track_out}, 32'h0);
      apb(1, OFS_CTRL, 32'h01);
      settle();
      expect_pos(1, 1000, 165);
      apb(1, OFS_CTRL, 32'h00);
      settle();
      check({31'h0, track_out}, 32'h0);
      apb(1, OFS_MOD, 32'd400); // Two tracks per modulo turn
      apb(1, OFS_CTRL, 32'h2B); // Time cams, modulo, actual position
      go(1212);
      expect_pos(1, 1200, 12);
      check(on_seen, 32'd10);
      apb(0, OFS_STAT, 0);
      check(rd, 32'h3);
      hom <= 1'b1;
      @(posedge clk);
      hom <= 1'b0;
      settle();
      check({31'h0, track_out}, 32'h1);
      repeat (500) @(posedge clk);
      check({31'h0, track_out}, 32'h0);
      apb(1, OFS_CTRL, 32'h51); // Distance cams, encoder, plain output
      settle();
      expect_pos(0, 1200, 32);
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
